// >>> design/gdi_top.sv
/*
  Device-side interface state logic for an instrument on a parallel
  instrument bus: remote/local with lockout, talker and listener state,
  service request, device clear, trigger and serial poll.
  Assumes an acceptor handshake on mclk delivers each command byte as a
  one-cycle cmd_valid, and a source handshake pulses stb_taken when the
  controller accepts a byte this block offers. Bus lines are low-true pins.
*/
// Function
// [R1] remote only when addressed to listen under enable
// [R2] remote blocks keys except local; indicator follows
// [R3] output-off key always works
// [R4] local key cancels remote, restores display
// [R5] lockout kills local key; cleared by go-to-local
// [R6] talk address sets talker; untalk, listen, clear reset
// [R7] listen address sets listener; unlisten, talk, clear reset
// [R8] interface clear: local, idle, indicators off; the code keeps srq_indicator_ff
// [R9] controller holds interface clear long enough
// [R10] enabled conditions raise a service request
// [R11] request indicator holds until polled or cleared
// [R12] device clear empties buffers, keeps settings
// [R13] universal clear acts unaddressed
// [R14] selected clear acts only when listening
// [R15] group trigger arms the trigger sequence
// [R16] poll returns status byte whenever addressed talk
// [R17] go-to-local leaves remote, re-enables keys
// [R18] own address configurable zero to thirty, default fifteen
// [R19] power-up: local, no lockout, idle, no request
`timescale 1ns/1ps
module gdi_top
  import gdi_pkg::*;
#(
  parameter int NKEY = 8,
  parameter int KEY_LOCAL = 0,
  parameter int KEY_OUT_OFF = 1,
  parameter int NCOND = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ren_n,
  input wire logic ifc_n,
  input wire logic atn_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [4:0] primary_addr,
  input wire logic [NKEY-1:0] key_in,
  input wire logic [NCOND-1:0] cond_in,
  input wire logic [NCOND-1:0] cond_enable,
  input wire logic [7:0] stb_in,
  input wire logic stb_taken,
  output logic remote_indicator_ff,
  output logic lockout_ff,
  output logic talk_indicator_ff,
  output logic listener_indicator_ff,
  output logic srq_indicator_ff,
  output logic srq_o_ff,
  output logic srq_oe_ff,
  output logic [NKEY-1:0] key_press_ff,
  output logic display_normal_ff,
  output logic dev_clear_ff,
  output logic trigger_arm_ff,
  output logic spoll_drive_ff,
  output logic [7:0] spoll_byte_ff
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  localparam int NSYNC = NKEY + 3;
  localparam logic [NSYNC-1:0] SYNC_IDLE = {3'h7, {NKEY{1'b0}}};

  logic [NSYNC-1:0] sync_q;
  logic ren;
  logic ifc;
  logic atn;
  logic [NKEY-1:0] key_lvl;

  gdi_sync #(.W(NSYNC)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({ren_n, ifc_n, atn_n, key_in}),
    .rst_val(SYNC_IDLE),
    .q(sync_q)
  );

  // [R9] interface clear is sampled as a level; a held pulse is assumed
  assign ren = ~sync_q[NKEY+2];
  assign ifc = ~sync_q[NKEY+1];
  assign atn = ~sync_q[NKEY];
  assign key_lvl = sync_q[NKEY-1:0];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic [4:0] my_addr;
  logic addr_ok;
  logic [6:0] msg;
  logic is_mla;
  logic is_mta;
  logic is_unl;
  logic is_unt;
  logic is_ota;
  logic listening;

  // [R18] address above thirty matches nothing
  assign addr_ok = primary_addr <= GDI_ADDR_MAX;
  assign my_addr = primary_addr;
  assign msg = cmd_byte[6:0];
  assign is_mla = cmd_valid && addr_ok && msg == {GDI_GRP_LISTEN, my_addr};
  assign is_mta = cmd_valid && addr_ok && msg == {GDI_GRP_TALK, my_addr};
  assign is_unl = cmd_valid && msg == {GDI_GRP_LISTEN, GDI_ADDR_UN};
  assign is_unt = cmd_valid && msg == {GDI_GRP_TALK, GDI_ADDR_UN};
  assign is_ota = cmd_valid && msg[6:5] == GDI_GRP_TALK && !is_mta && !is_unt;
  assign listening = listener_indicator_ff;

  // ---------------------------------------------------------------
  // remote / local state
  // ---------------------------------------------------------------
  gdi_rl_t rl_ff;
  gdi_rl_t nxt_rl;
  logic key_prev_ff;
  logic nxt_remote;
  logic nxt_lockout;
  logic local_press;
  logic nxt_display_normal;

  assign local_press = key_lvl[KEY_LOCAL] && !key_prev_ff;

  always_comb begin
    nxt_rl = rl_ff;
    nxt_display_normal = 1'b0;
    if (ifc || !ren) begin
      // [R8] leave remote, keep lockout until go-to-local
      nxt_rl = rl_ff[1] ? GDI_LWLS : GDI_LOCS;
    end else if (cmd_valid && msg == GDI_CMD_GTL && listening) begin
      nxt_rl = GDI_LOCS; // [R17] [R5]
    end else if (cmd_valid && msg == GDI_CMD_LLO) begin
      nxt_rl = rl_ff[0] ? GDI_RWLS : GDI_LWLS; // [R5]
    end else if (is_mla) begin
      nxt_rl = rl_ff[1] ? GDI_RWLS : GDI_REMS; // [R1]
    end else if (local_press && rl_ff == GDI_REMS) begin
      nxt_rl = GDI_LOCS; // [R4]
      nxt_display_normal = 1'b1; // [R4]
    end
    nxt_remote = nxt_rl[0]; // [R2]
    nxt_lockout = nxt_rl[1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rl_ff <= GDI_RL_RESET; // [R19]
      remote_indicator_ff <= 1'b0;
      lockout_ff <= 1'b0;
      display_normal_ff <= 1'b0;
    end else begin
      rl_ff <= nxt_rl;
      remote_indicator_ff <= nxt_remote;
      lockout_ff <= nxt_lockout;
      display_normal_ff <= nxt_display_normal;
    end
  end

  // ---------------------------------------------------------------
  // talker / listener addressing
  // ---------------------------------------------------------------
  logic nxt_talk;
  logic nxt_listen;

  always_comb begin
    nxt_talk = talk_indicator_ff;
    nxt_listen = listener_indicator_ff;
    if (ifc) begin
      nxt_talk = 1'b0; // [R8] [R6]
      nxt_listen = 1'b0; // [R8] [R7]
    end else begin
      if (is_mta) begin
        nxt_talk = 1'b1; // [R6]
        nxt_listen = 1'b0; // [R7]
      end else if (is_mla) begin
        nxt_listen = 1'b1; // [R7]
        nxt_talk = 1'b0; // [R6]
      end
      if (is_unt || is_ota) begin
        nxt_talk = 1'b0; // [R6]
      end
      if (is_unl) begin
        nxt_listen = 1'b0; // [R7]
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      talk_indicator_ff <= 1'b0; // [R19]
      listener_indicator_ff <= 1'b0;
    end else begin
      talk_indicator_ff <= nxt_talk;
      listener_indicator_ff <= nxt_listen;
    end
  end

  // ---------------------------------------------------------------
  // service request and serial poll
  // ---------------------------------------------------------------
  logic summary;
  logic summary_prev_ff;
  logic spe_ff;
  logic nxt_rqs;
  logic nxt_spe;
  logic nxt_drive;
  logic polled;
  logic [7:0] nxt_spoll_byte;

  assign summary = |(cond_in & cond_enable); // [R10]
  assign polled = spoll_drive_ff && stb_taken;

  always_comb begin
    nxt_rqs = srq_indicator_ff;
    if (!summary || polled) begin
      nxt_rqs = 1'b0; // [R11]
    end
    if (summary && !summary_prev_ff) begin
      nxt_rqs = 1'b1; // [R10] a new request wins over a clear
    end
    nxt_spe = spe_ff;
    if (ifc || (cmd_valid && msg == GDI_CMD_SPD)) begin
      nxt_spe = 1'b0; // [R16]
    end else if (cmd_valid && msg == GDI_CMD_SPE) begin
      nxt_spe = 1'b1; // [R16]
    end
    // [R16] offered whenever polled, request pending or not
    nxt_drive = nxt_spe && nxt_talk && !atn && !ifc;
    nxt_spoll_byte = stb_in;
    nxt_spoll_byte[GDI_STB_RQS_BIT] = nxt_rqs;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srq_indicator_ff <= 1'b0; // [R19]
      srq_o_ff <= 1'b0;
      srq_oe_ff <= 1'b0;
      summary_prev_ff <= 1'b0;
      spe_ff <= 1'b0;
      spoll_drive_ff <= 1'b0;
      spoll_byte_ff <= GDI_STB_RESET;
    end else begin
      srq_indicator_ff <= nxt_rqs;
      srq_o_ff <= 1'b0;
      srq_oe_ff <= nxt_rqs;
      summary_prev_ff <= summary;
      spe_ff <= nxt_spe;
      spoll_drive_ff <= nxt_drive;
      spoll_byte_ff <= nxt_spoll_byte;
    end
  end

  // ---------------------------------------------------------------
  // clear, trigger and panel keys
  // ---------------------------------------------------------------
  logic [NKEY-1:0] key_last_ff;
  logic [NKEY-1:0] nxt_key_press;
  logic nxt_dev_clear;
  logic nxt_trigger;
  logic panel_blocked;

  assign panel_blocked = rl_ff[0] || rl_ff[1];

  always_comb begin
    // [R13] universal clear, [R14] selected clear only while listening
    nxt_dev_clear = cmd_valid && (msg == GDI_CMD_DCL || (msg == GDI_CMD_SDC && listening));
    nxt_trigger = cmd_valid && msg == GDI_CMD_GET && listening; // [R15]
  end

  for (genvar k = 0; k < NKEY; k++) begin : g_key
    always_comb begin
      if (k == KEY_OUT_OFF) begin
        nxt_key_press[k] = key_lvl[k] && !key_last_ff[k]; // [R3]
      end else begin
        nxt_key_press[k] = key_lvl[k] && !key_last_ff[k] && !panel_blocked; // [R2] [R5]
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      key_last_ff <= '0;
      key_prev_ff <= 1'b0;
      key_press_ff <= '0;
      dev_clear_ff <= 1'b0;
      trigger_arm_ff <= 1'b0;
    end else begin
      key_last_ff <= key_lvl;
      key_prev_ff <= key_lvl[KEY_LOCAL];
      key_press_ff <= nxt_key_press;
      // [R12] one pulse flushes queues; settings are not touched here
      dev_clear_ff <= nxt_dev_clear;
      trigger_arm_ff <= nxt_trigger;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_listen_under_ren;
    is_mla && ren && !ifc;
  endsequence

  AST_REMOTE_ON_MLA: assert property (s_listen_under_ren |=> remote_indicator_ff) // [R1]
    else $error("remote not entered on listen address under enable");
  AST_REMOTE_NEEDS_MLA: assert property ($rose(remote_indicator_ff) |-> $past(is_mla)) // [R1]
    else $error("remote entered without listen address");
  AST_REMOTE_IND: assert property (remote_indicator_ff == rl_ff[0]) // [R2]
    else $error("remote indicator differs from state");
  AST_KEY_BLOCK: assert property (panel_blocked && KEY_OUT_OFF != 2 |=> !key_press_ff[2]) // [R2]
    else $error("panel key passed while blocked");
  AST_OUT_OFF: assert property (key_lvl[KEY_OUT_OFF] && !key_last_ff[KEY_OUT_OFF]
      |=> key_press_ff[KEY_OUT_OFF]) // [R3]
    else $error("output-off key lost");
  AST_LOCAL_KEY: assert property (rl_ff == GDI_REMS && local_press && ren && !ifc
      && !cmd_valid |=> !remote_indicator_ff && display_normal_ff) // [R4]
    else $error("local key did not cancel remote");
  AST_LOCKOUT_HOLD: assert property (rl_ff == GDI_RWLS && local_press && ren && !ifc
      && !cmd_valid |=> rl_ff == GDI_RWLS) // [R5]
    else $error("local key acted under lockout");
  AST_LOCKOUT_CLEAR: assert property ($fell(lockout_ff) |-> $past(cmd_valid && listening
      && msg == GDI_CMD_GTL)) // [R5]
    else $error("lockout cleared without go-to-local");

  sequence s_ifc_seen;
    ifc;
  endsequence
  sequence s_all_idle;
    !talk_indicator_ff && !listener_indicator_ff && !remote_indicator_ff;
  endsequence

  AST_IFC_IDLE: assert property (s_ifc_seen |=> s_all_idle) // [R8]
    else $error("interface clear left an active state");
  AST_TALK_LISTEN_EXCL: assert property (!(talk_indicator_ff && listener_indicator_ff)) // [R6]
    else $error("talker and listener both active");
  AST_MTA: assert property (is_mta && !ifc |=> talk_indicator_ff) // [R6]
    else $error("talk address not taken");
  AST_UNL: assert property (is_unl && !ifc |=> !listener_indicator_ff) // [R7]
    else $error("unlisten not honoured");
  AST_SRQ_SET: assert property (summary && !summary_prev_ff |=> srq_indicator_ff [*1]
      ##0 srq_oe_ff) // [R10]
    else $error("service request not raised");
  AST_SRQ_HOLD: assert property (srq_indicator_ff && summary && !polled
      && !$fell(summary) |=> srq_indicator_ff) // [R11]
    else $error("service request dropped early");
  AST_DCL: assert property (cmd_valid && msg == GDI_CMD_DCL |=> dev_clear_ff) // [R13]
    else $error("universal clear ignored");
  AST_SDC: assert property (cmd_valid && msg == GDI_CMD_SDC && !listening |=> !dev_clear_ff) // [R14]
    else $error("selected clear acted unaddressed");
  AST_GET: assert property (cmd_valid && msg == GDI_CMD_GET && listening |=> trigger_arm_ff) // [R15]
    else $error("trigger not armed");
  AST_POLL: assert property (spoll_drive_ff |-> spoll_byte_ff[GDI_STB_RQS_BIT]
      == srq_indicator_ff) // [R16]
    else $error("poll byte request bit wrong");

endmodule

// >>> design/gdi_pkg.sv
/*
  Shared constants and types for the instrument-bus interface state block:
  bus command codes, address layout, state encodings and reset values.
  Assumes the command codes arrive as the 7-bit message of a byte taken
  while attention is asserted; bit 7 (parity on some buses) is ignored.
*/
package gdi_pkg;

  // ---------------------------------------------------------------
  // command message codes
  // ---------------------------------------------------------------
  localparam logic [6:0] GDI_CMD_GTL = 7'h01;
  localparam logic [6:0] GDI_CMD_SDC = 7'h04;
  localparam logic [6:0] GDI_CMD_GET = 7'h08;
  localparam logic [6:0] GDI_CMD_LLO = 7'h11;
  localparam logic [6:0] GDI_CMD_DCL = 7'h14;
  localparam logic [6:0] GDI_CMD_SPE = 7'h18;
  localparam logic [6:0] GDI_CMD_SPD = 7'h19;

  // ---------------------------------------------------------------
  // address groups: upper two bits select listen or talk group
  // ---------------------------------------------------------------
  localparam logic [1:0] GDI_GRP_LISTEN = 2'h1;
  localparam logic [1:0] GDI_GRP_TALK = 2'h2;
  localparam logic [4:0] GDI_ADDR_UN = 5'h1F;
  localparam logic [4:0] GDI_ADDR_MAX = 5'h1E;
  localparam logic [4:0] GDI_ADDR_DEFAULT = 5'h0F;

  // ---------------------------------------------------------------
  // status byte layout
  // ---------------------------------------------------------------
  localparam int GDI_STB_RQS_BIT = 6;
  localparam logic [7:0] GDI_STB_RESET = 8'h00;

  // ---------------------------------------------------------------
  // remote/local states, gray coded: bit0 remote, bit1 lockout
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GDI_LOCS = 2'h0,
    GDI_REMS = 2'h1,
    GDI_RWLS = 2'h3,
    GDI_LWLS = 2'h2
  } gdi_rl_t;

  localparam gdi_rl_t GDI_RL_RESET = GDI_LOCS;

endpackage

// >>> design/gdi_sync.sv
/*
  Two-flop synchroniser for a vector of independent level inputs.
  Assumes each bit is a slow level; no relation between bits is kept.
*/
`timescale 1ns/1ps
module gdi_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // rst_val is held constant by the instantiator; flops reset to zero and
  // the polarity is folded in at the ports so reset takes a constant only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d ^ rst_val;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff ^ rst_val;

endmodule

// >>> dv/gdi_ctl_model.sv
/*
  Bus controller model: drives attention, remote enable, interface clear
  and command bytes, and accepts the poll byte that the device offers.
  Assumes the device samples its inputs on the rising edge of mclk.
*/
`timescale 1ns/1ps
module gdi_ctl_model #(
  parameter int IFC_CYC = 25000
) (
  input wire logic mclk,
  input wire logic spoll_drive_ff,
  input wire logic [7:0] spoll_byte_ff,
  output logic ren_n,
  output logic ifc_n,
  output logic atn_n,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic stb_taken
);
  initial begin
    ren_n = 1'b1;
    ifc_n = 1'b1;
    atn_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    stb_taken = 1'b0;
  end
  // one byte under attention; the byte lines scramble once released
  task automatic send(input logic [7:0] b);
    @(negedge mclk);
    atn_n = 1'b0;
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  endtask
  task automatic set_ren(input logic on);
    @(negedge mclk);
    ren_n = ~on;
    repeat (3) @(negedge mclk);
  endtask
  task automatic pulse_ifc();
    @(negedge mclk);
    ifc_n = 1'b0;
    repeat (IFC_CYC) @(negedge mclk); // clear held for its minimum width
    ifc_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  // drops attention, waits for the offer, accepts it after dly cycles
  task automatic take_byte(input int dly, output logic [7:0] b, output logic seen);
    int n;
    n = 0;
    @(negedge mclk);
    atn_n = 1'b1;
    while (spoll_drive_ff !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    seen = spoll_drive_ff;
    repeat (dly) @(negedge mclk);
    // the offered byte stands until the accepting edge, so it is taken here
    stb_taken = 1'b1;
    b = spoll_byte_ff;
    @(posedge mclk);
    @(negedge mclk);
    stb_taken = 1'b0;
  endtask
endmodule

// >>> dv/gdi_top_tb.sv
/*
  Self-checking bench for the interface state block: bus commands, pins,
  panel keys, service request and serial poll.
  Assumes gdi_ctl_model stands for the bus controller.
*/
`timescale 1ns/1ps
module gdi_top_tb;
  import gdi_pkg::*;
  localparam logic [6:0] MLA = {GDI_GRP_LISTEN, GDI_ADDR_DEFAULT};
  localparam logic [6:0] MTA = {GDI_GRP_TALK, GDI_ADDR_DEFAULT};
  localparam logic [6:0] UNL = {GDI_GRP_LISTEN, GDI_ADDR_UN};
  localparam logic [6:0] UNT = {GDI_GRP_TALK, GDI_ADDR_UN};
  logic mclk, rst, ren_n, ifc_n, atn_n, cv, stb_taken;
  logic rmt, lko, tlk, lsn, srq, so, soe, dn, dc, ta, sd;
  logic [7:0] cb, stb_in, sb, key_in, cond_in, cond_en, kp;
  logic [4:0] pa;
  int n_mismatch = 0;
  int compares = 0;
  int c_clr = 0;
  int c_trg = 0;
  int c_disp = 0;
  int c_off = 0;
  int c_k2 = 0;

  gdi_top i_dut (.mclk(mclk), .rst(rst), .ren_n(ren_n), .ifc_n(ifc_n), .atn_n(atn_n),
    .cmd_valid(cv), .cmd_byte(cb), .primary_addr(pa), .key_in(key_in), .cond_in(cond_in),
    .cond_enable(cond_en), .stb_in(stb_in), .stb_taken(stb_taken),
    .remote_indicator_ff(rmt), .lockout_ff(lko), .talk_indicator_ff(tlk),
    .listener_indicator_ff(lsn), .srq_indicator_ff(srq), .srq_o_ff(so), .srq_oe_ff(soe),
    .key_press_ff(kp), .display_normal_ff(dn), .dev_clear_ff(dc), .trigger_arm_ff(ta),
    .spoll_drive_ff(sd), .spoll_byte_ff(sb));
  gdi_ctl_model i_ctl (.mclk(mclk), .spoll_drive_ff(sd), .spoll_byte_ff(sb),
    .ren_n(ren_n), .ifc_n(ifc_n), .atn_n(atn_n), .cmd_valid(cv), .cmd_byte(cb),
    .stb_taken(stb_taken));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // one-cycle pulses are counted mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    c_clr += (dc === 1'b1);
    c_trg += (ta === 1'b1);
    c_disp += (dn === 1'b1);
    c_off += (kp[1] === 1'b1);
    c_k2 += (kp[2] === 1'b1);
  end

  // ---------------------------------------------------------------
  // compare and drive helpers
  // ---------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic tx(input logic [6:0] c);
    i_ctl.send({1'b0, c});
    wt(2);
  endtask
  task automatic press(input int k);
    wt(1);
    key_in[k] = 1'b1;
    wt(4);
    key_in[k] = 1'b0;
    wt(4);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_remote();
    chk_byte("power-up", 8'h00, {1'b0, rmt, lko, tlk, lsn, srq, soe, sd});
    tx(MLA);
    chk_bit("listen", 1'b1, lsn);
    chk_bit("remote no enable", 1'b0, rmt);
    tx(UNL);
    chk_bit("unlisten", 1'b0, lsn);
    i_ctl.set_ren(1'b1);
    wt(3);
    chk_bit("enable alone", 1'b0, rmt);
    tx(MLA);
    chk_bit("remote", 1'b1, rmt);
  endtask
  task automatic t_keys();
    int k2, off, d;
    k2 = c_k2;
    off = c_off;
    d = c_disp;
    press(2);
    chk_cnt("blocked key", 0, c_k2 - k2);
    press(1);
    chk_cnt("output off", 1, c_off - off);
    press(0);
    chk_bit("local key", 1'b0, rmt);
    chk_cnt("display restore", 1, c_disp - d);
    press(2);
    chk_cnt("panel back", 1, c_k2 - k2);
  endtask
  task automatic t_lockout();
    int k2, off;
    tx(MLA);
    tx(GDI_CMD_LLO);
    chk_bit("lockout", 1'b1, lko);
    k2 = c_k2;
    off = c_off;
    press(0);
    chk_bit("local dead", 1'b1, rmt);
    press(1);
    chk_cnt("off in lockout", 1, c_off - off);
    tx(GDI_CMD_GTL);
    chk_bit("gtl remote", 1'b0, rmt);
    chk_bit("gtl lockout", 1'b0, lko);
    press(2);
    chk_cnt("keys after gtl", 1, c_k2 - k2);
  endtask
  task automatic t_addr_roles();
    tx(MTA);
    chk_byte("talk", 8'h02, {6'h00, tlk, lsn});
    tx(MLA);
    chk_byte("listen", 8'h01, {6'h00, tlk, lsn});
    tx(MTA);
    tx(UNT);
    chk_byte("untalk", 8'h00, {6'h00, tlk, lsn});
    tx(MTA);
    tx({GDI_GRP_TALK, 5'h03});
    chk_bit("other talker", 1'b0, tlk);
  endtask
  task automatic t_clear();
    int cl, tr;
    cl = c_clr;
    tr = c_trg;
    tx(GDI_CMD_SDC);
    tx(GDI_CMD_GET);
    chk_cnt("sdc unaddressed", 0, c_clr - cl);
    chk_cnt("get unaddressed", 0, c_trg - tr);
    tx(GDI_CMD_DCL);
    chk_cnt("dcl", 1, c_clr - cl);
    tx(MLA);
    tx(GDI_CMD_SDC);
    chk_cnt("sdc", 2, c_clr - cl);
    chk_bit("state kept", 1'b1, rmt);
    tx(GDI_CMD_GET);
    chk_cnt("trigger", 1, c_trg - tr);
  endtask
  task automatic t_poll();
    logic [7:0] b;
    logic seen;
    cond_in[0] = 1'b1;
    wt(3);
    chk_bit("masked cond", 1'b0, srq);
    cond_in[3] = 1'b1;
    wt(3);
    chk_byte("request", 8'h03, {6'h00, srq, soe});
    chk_bit("srq line value", 1'b0, so);
    tx(GDI_CMD_SPE);
    tx(MTA);
    i_ctl.take_byte(3, b, seen);
    chk_bit("poll offer", 1'b1, seen);
    chk_byte("poll byte", 8'hC5, b);
    wt(2);
    chk_byte("read clears", 8'h00, {6'h00, srq, soe});
    chk_byte("byte after read", 8'h85, sb);
    tx(GDI_CMD_SPD);
    chk_bit("poll end", 1'b0, sd);
    tx(GDI_CMD_SPE);
    tx(MTA);
    i_ctl.take_byte(0, b, seen);
    chk_byte("idle poll", 8'h85, b);
    tx(GDI_CMD_SPD);
    cond_in = 8'h00;
    wt(3);
  endtask
  task automatic t_ifc();
    tx(MLA);
    tx(MTA);
    cond_in[3] = 1'b1;
    wt(3);
    i_ctl.pulse_ifc();
    chk_byte("ifc", 8'h00, {5'h00, rmt, tlk, lsn});
    chk_bit("ifc keeps request", 1'b1, srq);
    cond_in[3] = 1'b0;
    wt(3);
    chk_bit("cond cleared", 1'b0, srq);
  endtask
  task automatic t_addr();
    pa = GDI_ADDR_MAX;
    wt(2);
    tx(MLA);
    chk_bit("old address", 1'b0, lsn);
    tx({GDI_GRP_LISTEN, GDI_ADDR_MAX});
    chk_bit("address 30", 1'b1, lsn);
    chk_bit("remote at 30", 1'b1, rmt);
    i_ctl.set_ren(1'b0);
    wt(2);
    chk_bit("enable dropped", 1'b0, rmt);
    tx(UNL);
  endtask

  initial begin
    rst = 1'b1;
    key_in = 8'h00;
    cond_in = 8'h00;
    cond_en = 8'h08;
    stb_in = 8'h85;
    pa = GDI_ADDR_DEFAULT;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    wt(2);
    t_remote();
    t_keys();
    t_lockout();
    t_addr_roles();
    t_clear();
    t_poll();
    t_ifc();
    t_addr();
    tally_and_finish();
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
